// *** tcs_consts.svh ***
`ifndef TCS_CONSTS_SVH
`define TCS_CONSTS_SVH

// Per-channel register offsets inside one 64-byte channel window
`define TCS_OFF_B        6'h18
`define TCS_OFF_C        6'h1c
`define TCS_OFF_SR       6'h20
`define TCS_OFF_IER      6'h24
`define TCS_OFF_IDR      6'h28
`define TCS_OFF_IMR      6'h2c

// Block-level registers
`define TCS_OFF_BCR      8'hc0
`define TCS_OFF_BMR      8'hc4

// Channel count
`define TCS_NCHAN        3

// Reset values
`define TCS_RST_DATA     16'h0000
`define TCS_RST_MASK     8'h00
`define TCS_RST_BMR      6'h00

// Status bit positions
`define TCS_BIT_WRAP     0
`define TCS_BIT_OVR      1
`define TCS_BIT_MA       2
`define TCS_BIT_MB       3
`define TCS_BIT_MC       4
`define TCS_BIT_LDA      5
`define TCS_BIT_LDB      6
`define TCS_BIT_ETRG     7
`define TCS_BIT_CLKON    16
`define TCS_BIT_MIRA     17
`define TCS_BIT_MIRB     18

// Block control and routing fields
`define TCS_BIT_SYNC     0
`define TCS_SEL_PIN      2'h0
`define TCS_SEL_NONE     2'h1
`define TCS_SEL_LO       2'h2
`define TCS_SEL_HI       2'h3

`endif

// *** tcs_pkg.sv ***
package tcs_pkg;
	typedef logic [7:0]  tcs_flags_t;
	typedef logic [15:0] tcs_data_t;
	typedef logic [1:0]  tcs_route_t;
endpackage

// *** tcs_chan_flags.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "tcs_consts.svh"

module tcs_chan_flags
	import tcs_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic clk_en,
	input  wire logic wave,
	input  wire logic ext_trig,
	input  wire logic load_a,
	input  wire logic load_b,
	input  wire logic match_a,
	input  wire logic match_b,
	input  wire logic match_c,
	input  wire logic wrap,
	input  wire logic status_rd,
	input  wire logic a_rd,
	input  wire logic b_rd,
	output var tcs_flags_t flags,
	output var tcs_flags_t set_vec
);
	tcs_flags_t flags_q;
	tcs_flags_t flags_d;
	logic       a_unread_q;
	logic       b_unread_q;
	logic       overrun;

	// Event sources for each flag; load, A/B match and overrun are mode-gated
	always_comb begin
		set_vec = 8'h00;
		overrun = ~wave & ((load_a & a_unread_q) | (load_b & b_unread_q)); // [RULE11]
		set_vec[`TCS_BIT_ETRG] = ext_trig;                  // [RULE7]
		set_vec[`TCS_BIT_LDB]  = load_b & ~wave;            // [RULE8] [RULE20]
		set_vec[`TCS_BIT_LDA]  = load_a & ~wave;            // [RULE8]
		set_vec[`TCS_BIT_MC]   = match_c;                   // [RULE9]
		set_vec[`TCS_BIT_MB]   = match_b & wave;            // [RULE10] [RULE20]
		set_vec[`TCS_BIT_MA]   = match_a & wave;            // [RULE10]
		set_vec[`TCS_BIT_OVR]  = overrun;                   // [RULE11]
		set_vec[`TCS_BIT_WRAP] = wrap;                      // [RULE12]
		// Set beats the read clear so no event slips through
		flags_d = (status_rd ? 8'h00 : flags_q) | set_vec;  // [RULE3] [RULE22]
	end

	// Sticky flags
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			flags_q <= 8'h00;
		end else if (clk_en) begin
			flags_q <= flags_d;
		end
	end

	// Unread tracking; a load in the read cycle keeps it pending
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			a_unread_q <= 1'b0;
			b_unread_q <= 1'b0;
		end else if (clk_en) begin
			a_unread_q <= (load_a & ~wave) | (a_unread_q & ~a_rd); // [RULE11]
			b_unread_q <= (load_b & ~wave) | (b_unread_q & ~b_rd); // [RULE11]
		end
	end

	assign flags = flags_q;
endmodule

`default_nettype wire

// *** tcs_top.sv ***
// Notes on behaviour
// RULE1: B register read only in capture mode, written only in waveform mode.
// RULE2: C register reads and writes in all modes, holds sixteen bits.
// RULE3: Reading channel status clears its event flags.
// RULE4: Status bit 18 shows B line: pin in capture, driven in waveform.
// RULE5: Status bit 17 shows A line: pin in capture, driven in waveform.
// RULE6: Status bit 16 follows counter clock enable, never cleared by read.
// RULE7: Bit 7 sets on external trigger, clears on status read.
// RULE8: Bits 6 and 5 set on B or A load, capture mode only.
// RULE9: Bit 4 sets on C match in any mode.
// RULE10: Bits 3 and 2 set on B or A match, waveform mode only.
// RULE11: Bit 1 sets on second unread A or B load in capture.
// RULE12: Bit 0 sets on counter overflow.
// RULE13: Enable-set register ones set mask bits, zeros ignored.
// RULE14: Enable-clear register ones clear mask bits, zeros ignored.
// RULE15: Mask register reads enabled sources, resets to zero.
// RULE16: Block control bit 0 fires software trigger on all channels together.
// RULE17: Clock input 2 select: pin 2, none, channel 0 A, channel 1 A.
// RULE18: Clock input 1 select: pin 1, none, channel 0 A, channel 2 A.
// RULE19: Clock input 0 select: pin 0, none, channel 1 A, channel 2 A.
// RULE20: Mode bit one means waveform, zero capture; steers access and flags.
// RULE21: Channel interrupt asserts while any enabled flag is set.
// RULE22: A flag set in its clearing read cycle stays set.
`timescale 1ns/10ps
`default_nettype none
`include "tcs_consts.svh"

module tcs_top
	import tcs_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              rst,
	input  wire logic              clk_en,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [7:0]        wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	input  wire logic [2:0]        waveform_mode_select,
	input  wire logic [2:0]        counter_clock_on,
	input  wire logic [2:0]        channel_line_a_pin,
	input  wire logic [2:0]        channel_line_b_pin,
	input  wire logic [2:0]        channel_line_a_drive,
	input  wire logic [2:0]        channel_line_b_drive,
	input  wire logic [2:0]        ext_trig_evt,
	input  wire logic [2:0]        load_a_evt,
	input  wire logic [2:0]        load_b_evt,
	input  wire logic [2:0]        match_a_evt,
	input  wire logic [2:0]        match_b_evt,
	input  wire logic [2:0]        match_c_evt,
	input  wire logic [2:0]        counter_wrap_evt,
	input  wire logic [2:0]        capture_compare_a_rd,
	input  wire logic [2:0][15:0]  counter_value,
	input  wire logic [2:0]        ext_clock_pin,
	output logic      [2:0]        chan_irq,
	output logic      [2:0]        sw_trigger,
	output logic      [2:0][15:0]  capture_compare_b_val,
	output logic      [2:0][15:0]  compare_c_val,
	output logic      [2:0]        ext_clock_in
);
	// Bus-side state
	logic              ack_q;
	logic [31:0]       dat_q;
	logic [31:0]       rdata;
	logic [31:0]       wmask;
	logic [31:0]       wdat_m;
	logic              take;
	logic              rd_take;
	logic              wr_take;

	// Register storage, indexed by channel
	tcs_data_t         b_q [3];
	tcs_data_t         c_q [3];
	tcs_flags_t        mask_q [3];
	tcs_flags_t        flags [3];
	tcs_flags_t        set_vec [3];
	logic [5:0]        bmr_q;
	logic [2:0]        irq_q;
	logic [2:0]        trig_q;
	logic [2:0]        xc_q;

	// Decoded hits per channel
	logic [2:0]        hit_b;
	logic [2:0]        hit_c;
	logic [2:0]        hit_sr;
	logic [2:0]        hit_ier;
	logic [2:0]        hit_idr;
	logic [2:0]        hit_imr;
	logic              hit_bcr;
	logic              hit_bmr;
	logic [2:0]        status_rd;
	logic [2:0]        b_rd;

	// Pin synchronisers: stage one feeds only stage two
	logic [2:0]        apin_s1_q;
	logic [2:0]        apin_s2_q;
	logic [2:0]        bpin_s1_q;
	logic [2:0]        bpin_s2_q;
	logic [2:0]        xpin_s1_q;
	logic [2:0]        xpin_s2_q;
	logic [2:0]        mirror_a;
	logic [2:0]        mirror_b;

	// One-hot channel hit for a given in-window offset
	function automatic logic [2:0] chan_hit(input logic [7:0] adr,
	                                        input logic [5:0] off);
		logic [2:0] hit;
		hit = 3'h0;
		for (int n = 0; n < `TCS_NCHAN; n++) begin
			hit[n] = (adr[7:6] == 2'(n)) && (adr[5:0] == off);
		end
		return hit;
	endfunction

	// Byte-lane merge of write data into an old value
	function automatic tcs_data_t merge16(input tcs_data_t old,
	                                      input logic [31:0] dat,
	                                      input logic [3:0] sel);
		tcs_data_t res;
		res = old;
		if (sel[0]) res[7:0] = dat[7:0];
		if (sel[1]) res[15:8] = dat[15:8];
		return res;
	endfunction

	// External clock routing: pin, none, then two sibling A lines
	function automatic logic route(input tcs_route_t sel, input logic pin,
	                               input logic lo, input logic hi);
		logic r;
		case (sel)
			`TCS_SEL_PIN:  r = pin;
			`TCS_SEL_NONE: r = 1'b0;
			`TCS_SEL_LO:   r = lo;
			`TCS_SEL_HI:   r = hi;
			default:       r = 1'b0;
		endcase
		return r;
	endfunction

	// Request decode; effects land on the taking edge
	assign take    = wb_cyc_i & wb_stb_i & ~ack_q;
	assign rd_take = take & ~wb_we_i;
	assign wr_take = take & wb_we_i;
	assign hit_b   = chan_hit(wb_adr_i, `TCS_OFF_B);
	assign hit_c   = chan_hit(wb_adr_i, `TCS_OFF_C);
	assign hit_sr  = chan_hit(wb_adr_i, `TCS_OFF_SR);
	assign hit_ier = chan_hit(wb_adr_i, `TCS_OFF_IER);
	assign hit_idr = chan_hit(wb_adr_i, `TCS_OFF_IDR);
	assign hit_imr = chan_hit(wb_adr_i, `TCS_OFF_IMR);
	assign hit_bcr = (wb_adr_i == `TCS_OFF_BCR);
	assign hit_bmr = (wb_adr_i == `TCS_OFF_BMR);
	assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
	                  {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wdat_m  = wb_dat_i & wmask;
	assign status_rd = {3{rd_take}} & hit_sr;                          // [RULE3]
	assign b_rd      = {3{rd_take}} & hit_b & ~waveform_mode_select;   // [RULE11]

	// Line mirrors pick pin or driven level by mode
	assign mirror_a = (waveform_mode_select & channel_line_a_drive) |
	                  (~waveform_mode_select & apin_s2_q);             // [RULE5]
	assign mirror_b = (waveform_mode_select & channel_line_b_drive) |
	                  (~waveform_mode_select & bpin_s2_q);             // [RULE4]

	// Read mux; unmapped and write-only locations answer zero
	always_comb begin
		rdata = 32'h0;
		for (int n = 0; n < `TCS_NCHAN; n++) begin
			if (hit_b[n] && !waveform_mode_select[n]) begin
				rdata = {16'h0, b_q[n]};                                // [RULE1] [RULE20]
			end
			if (hit_c[n]) begin
				rdata = {16'h0, c_q[n]};                                // [RULE2]
			end
			if (hit_sr[n]) begin
				rdata = {13'h0, mirror_b[n], mirror_a[n],
				         counter_clock_on[n], 8'h0, flags[n]};          // [RULE6]
			end
			if (hit_imr[n]) begin
				rdata = {24'h0, mask_q[n]};                             // [RULE15]
			end
		end
		if (hit_bmr) begin
			rdata = {26'h0, bmr_q};
		end
	end

	// Bus answer: ack one cycle after take, dropped the next
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0;
		end else if (clk_en) begin
			ack_q <= take;
			if (rd_take) begin
				dat_q <= rdata;
			end
		end
	end

	// Pin synchronisers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			apin_s1_q <= 3'h0;
			apin_s2_q <= 3'h0;
			bpin_s1_q <= 3'h0;
			bpin_s2_q <= 3'h0;
			xpin_s1_q <= 3'h0;
			xpin_s2_q <= 3'h0;
		end else if (clk_en) begin
			apin_s1_q <= channel_line_a_pin;
			apin_s2_q <= apin_s1_q;
			bpin_s1_q <= channel_line_b_pin;
			bpin_s2_q <= bpin_s1_q;
			xpin_s1_q <= ext_clock_pin;
			xpin_s2_q <= xpin_s1_q;
		end
	end

	// Per-channel registers, flags and interrupt line
	generate
		for (genvar n = 0; n < `TCS_NCHAN; n++) begin : g_chan
			// B: hardware capture load, bus write only in waveform mode
			always_ff @(posedge ref_clk) begin
				if (rst) begin
					b_q[n] <= `TCS_RST_DATA;
				end else if (clk_en) begin
					if (load_b_evt[n] && !waveform_mode_select[n]) begin
						b_q[n] <= counter_value[n];
					end else if (wr_take && hit_b[n] &&
					             waveform_mode_select[n]) begin
						b_q[n] <= merge16(b_q[n], wb_dat_i, wb_sel_i); // [RULE1]
					end
				end
			end

			// C: plain read/write in every mode
			always_ff @(posedge ref_clk) begin
				if (rst) begin
					c_q[n] <= `TCS_RST_DATA;
				end else if (clk_en && wr_take && hit_c[n]) begin
					c_q[n] <= merge16(c_q[n], wb_dat_i, wb_sel_i);     // [RULE2]
				end
			end

			// Mask: set and clear ports; the set port is checked first, clear only otherwise
			always_ff @(posedge ref_clk) begin
				if (rst) begin
					mask_q[n] <= `TCS_RST_MASK;                         // [RULE15]
				end else if (clk_en && wr_take) begin
					if (hit_ier[n]) begin
						mask_q[n] <= mask_q[n] | wdat_m[7:0];          // [RULE13]
					end else if (hit_idr[n]) begin
						mask_q[n] <= mask_q[n] & ~wdat_m[7:0];         // [RULE14]
					end
				end
			end

			tcs_chan_flags u_flags (
				.ref_clk   (ref_clk),
				.rst       (rst),
				.clk_en    (clk_en),
				.wave      (waveform_mode_select[n]),
				.ext_trig  (ext_trig_evt[n]),
				.load_a    (load_a_evt[n]),
				.load_b    (load_b_evt[n]),
				.match_a   (match_a_evt[n]),
				.match_b   (match_b_evt[n]),
				.match_c   (match_c_evt[n]),
				.wrap      (counter_wrap_evt[n]),
				.status_rd (status_rd[n]),
				.a_rd      (capture_compare_a_rd[n]),
				.b_rd      (b_rd[n]),
				.flags     (flags[n]),
				.set_vec   (set_vec[n])
			);

			// Registered so the line is glitch free to the controller
			always_ff @(posedge ref_clk) begin
				if (rst) begin
					irq_q[n] <= 1'b0;
				end else if (clk_en) begin
					irq_q[n] <= |(flags[n] & mask_q[n]);               // [RULE21]
				end
			end

			assign capture_compare_b_val[n] = b_q[n];
			assign compare_c_val[n]         = c_q[n];
		end
	endgenerate

	// Block mode register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			bmr_q <= `TCS_RST_BMR;
		end else if (clk_en && wr_take && hit_bmr && wb_sel_i[0]) begin
			bmr_q <= wb_dat_i[5:0];
		end
	end

	// Software trigger: one-cycle pulse to all channels at once
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			trig_q <= 3'h0;
		end else if (clk_en) begin
			trig_q <= {3{wr_take & hit_bcr & wb_sel_i[0] &
			             wb_dat_i[`TCS_BIT_SYNC]}};                 // [RULE16]
		end
	end

	// External clock routing; adds one cycle of latency
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			xc_q <= 3'h0;
		end else if (clk_en) begin
			xc_q[2] <= route(bmr_q[5:4], xpin_s2_q[2],
			                 channel_line_a_drive[0],
			                 channel_line_a_drive[1]);              // [RULE17]
			xc_q[1] <= route(bmr_q[3:2], xpin_s2_q[1],
			                 channel_line_a_drive[0],
			                 channel_line_a_drive[2]);              // [RULE18]
			xc_q[0] <= route(bmr_q[1:0], xpin_s2_q[0],
			                 channel_line_a_drive[1],
			                 channel_line_a_drive[2]);              // [RULE19]
		end
	end

	assign wb_ack_o     = ack_q;
	assign wb_dat_o     = dat_q;
	assign chan_irq     = irq_q;
	assign sw_trigger   = trig_q;
	assign ext_clock_in = xc_q;

	// Checks
	sequence s_take;
		clk_en && take;
	endsequence

	sequence s_ack_pulse;
		wb_ack_o ##1 !wb_ack_o;
	endsequence

	a_bus_ack_pulse: assert property (@(posedge ref_clk) disable iff (rst)
		(s_take ##1 clk_en) |-> s_ack_pulse)
		else $error("ack not a single cycle after take");

	a_mask_set_bits: assert property (@(posedge ref_clk) disable iff (rst) // [RULE13]
		(clk_en && wr_take && hit_ier[0]) |=>
		((mask_q[0] & $past(wdat_m[7:0])) == $past(wdat_m[7:0])))
		else $error("enable-set did not set mask");

	a_mask_clr_bits: assert property (@(posedge ref_clk) disable iff (rst) // [RULE14]
		(clk_en && wr_take && hit_idr[1]) |=>
		((mask_q[1] & $past(wdat_m[7:0])) == 8'h00))
		else $error("enable-clear did not clear mask");

	a_sync_all_chan: assert property (@(posedge ref_clk) disable iff (rst) // [RULE16]
		(clk_en && wr_take && hit_bcr && wb_sel_i[0] && wb_dat_i[0]) |=>
		(sw_trigger == 3'h7) ##1 (!$past(clk_en) || sw_trigger == 3'h0))
		else $error("software trigger not a common pulse");

	a_read_clears: assert property (@(posedge ref_clk) disable iff (rst) // [RULE3]
		(clk_en && status_rd[0] && set_vec[0] == 8'h00) |=>
		(flags[0] == 8'h00))
		else $error("status read left flags set");

	a_set_beats_clr: assert property (@(posedge ref_clk) disable iff (rst) // [RULE22]
		(clk_en && status_rd[2]) |=>
		((flags[2] & $past(set_vec[2])) == $past(set_vec[2])))
		else $error("event lost in clearing read");

	a_irq_enabled: assert property (@(posedge ref_clk) disable iff (rst) // [RULE21]
		(clk_en && (flags[0] & mask_q[0]) == 8'h00) |=> !chan_irq[0])
		else $error("interrupt without enabled flag");

	a_b_wave_write: assert property (@(posedge ref_clk) disable iff (rst) // [RULE1]
		(clk_en && wr_take && hit_b[0] && waveform_mode_select[0] &&
		 !load_b_evt[0] && wb_sel_i == 4'hf) |=>
		(capture_compare_b_val[0] == $past(wb_dat_i[15:0])))
		else $error("B write in waveform mode lost");

	a_xc2_route_a0: assert property (@(posedge ref_clk) disable iff (rst) // [RULE17]
		(clk_en && bmr_q[5:4] == 2'h2) |=>
		(ext_clock_in[2] == $past(channel_line_a_drive[0])))
		else $error("clock input 2 not routed to channel 0 A");

	a_clk_on_read: assert property (@(posedge ref_clk) disable iff (rst) // [RULE6]
		(clk_en && status_rd[1]) |=>
		(wb_dat_o[`TCS_BIT_CLKON] == $past(counter_clock_on[1])))
		else $error("clock status bit wrong in read");
endmodule

`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "tcs_consts.svh"

module tb_top;
	localparam logic [7:0] a_b   = {2'h0, `TCS_OFF_B};
	localparam logic [7:0] a_c   = {2'h0, `TCS_OFF_C};
	localparam logic [7:0] a_sr  = {2'h0, `TCS_OFF_SR};
	localparam logic [7:0] a_ier = {2'h0, `TCS_OFF_IER};
	localparam logic [7:0] a_idr = {2'h0, `TCS_OFF_IDR};
	localparam logic [7:0] a_imr = {2'h0, `TCS_OFF_IMR};

	logic             ref_clk = 1'b0;
	logic             rst     = 1'b1;
	logic             en      = 1'b1;
	logic             cyc     = 1'b0;
	logic             stb     = 1'b0;
	logic             we      = 1'b0;
	logic [7:0]       adr     = 8'h00;
	logic [31:0]      dat     = 32'h0;
	logic [2:0]       wave    = 3'h0;
	logic [2:0]       clk_on  = 3'h0;
	logic [2:0]       pin_a   = 3'h0;
	logic [2:0]       pin_b   = 3'h0;
	logic [2:0]       drv_a   = 3'h0;
	logic [2:0]       drv_b   = 3'h0;
	logic [2:0]       xpin    = 3'h0;
	logic [2:0]       ev [0:7];
	logic [2:0][15:0] cnt_val = {3{16'h1234}};
	logic [31:0]      q;
	wire logic [31:0]      rdat;
	wire logic             ack;
	wire logic [2:0]       irq;
	wire logic [2:0]       swt;
	wire logic [2:0]       xin;
	wire logic [2:0][15:0] bval;
	wire logic [2:0][15:0] cval;
	int               miscompares = 0;
	int               check_count = 0;
	int               trig_cnt    = 0;
	int               odd_cnt     = 0;

	// Free-running bus clock, 4 ns period
	always #2 ref_clk = ~ref_clk;

	initial begin
		for (int i = 0; i < 8; i++) begin
			ev[i] = 3'h0;
		end
	end

	// Event slot 1 carries the A-register read strobe
	tcs_top tcs_top_i (
		.ref_clk(ref_clk), .rst(rst), .clk_en(en),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.waveform_mode_select(wave), .counter_clock_on(clk_on),
		.channel_line_a_pin(pin_a), .channel_line_b_pin(pin_b),
		.channel_line_a_drive(drv_a), .channel_line_b_drive(drv_b),
		.ext_trig_evt(ev[7]), .load_a_evt(ev[5]), .load_b_evt(ev[6]),
		.match_a_evt(ev[2]), .match_b_evt(ev[3]), .match_c_evt(ev[4]),
		.counter_wrap_evt(ev[0]), .capture_compare_a_rd(ev[1]),
		.counter_value(cnt_val), .ext_clock_pin(xpin), .chan_irq(irq),
		.sw_trigger(swt), .capture_compare_b_val(bval),
		.compare_c_val(cval), .ext_clock_in(xin)
	);

	// Count trigger pulses; a partial one means channels fired apart
	always @(posedge ref_clk) begin
		if (!rst && swt === 3'b111) begin
			trig_cnt++;
		end else if (!rst && swt !== 3'b000) begin
			odd_cnt++;
		end
	end

	task automatic complete_run();
		if (miscompares == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk32(input string nm, input logic [31:0] e,
			input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk3(input string nm, input logic [2:0] e,
			input logic [2:0] g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %b seen %b", nm, e, g);
		end
	endtask

	// Classic single cycle; request held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a,
			input logic [31:0] d, output logic [31:0] r);
		int n;
		@(posedge ref_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (ack !== 1'b1) begin
			miscompares++;
			complete_run();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		wb(1'b1, a, d, r);
	endtask

	task automatic rdc(input string nm, input logic [7:0] a,
			input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
		logic [31:0] r;
		wb(1'b0, a, 32'h0, r);
		chk32(nm, e, r & m);
	endtask

	// One-cycle pulse on an event input of one channel
	task automatic pulse(input int b, input int ch);
		@(posedge ref_clk);
		ev[b][ch] <= 1'b1;
		@(posedge ref_clk);
		ev[b][ch] <= 1'b0;
	endtask

	function automatic logic route(input logic p, input logic lo,
			input logic hi, input int s);
		return (s == 0) ? p : (s == 1) ? 1'b0 : (s == 2) ? lo : hi;
	endfunction

	initial begin
		logic ok;
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		rdc("mask reset", a_imr, 32'h0);
		rdc("c reset", a_c, 32'h0);
		rdc("routing reset", `TCS_OFF_BMR, 32'h0);
		rdc("unmapped", 8'h00, 32'h0);
		rdc("enable set reads zero", a_ier, 32'h0);
		// Flag table in both modes; every flag except bit 1 read twice
		for (int m = 0; m < 2; m++) begin
			@(posedge ref_clk);
			wave[0] <= m[0];
			wr(a_c, 32'hffffab00 | m);
			rdc("c value", a_c, 32'h0000ab00 | m);
			chk32("c port", 32'h0000ab00 | m, {16'h0, cval[0]});
			wb(1'b0, a_sr, 32'h0, q);
			for (int b = 0; b < 8; b++) begin
				ok = (b == 0 || b == 4 || b == 7) ||
					(m == 1 && (b == 2 || b == 3)) ||
					(m == 0 && (b == 5 || b == 6));
				if (b != 1) begin
					pulse(b, 0);
					rdc("flag", a_sr, ok ? 32'h1 << b : 0, 32'hff);
					rdc("flag clear", a_sr, 32'h0, 32'hff);
				end
			end
		end
		// Register B: written in waveform, read in capture
		wr(a_b, 32'hffff5678);
		chk32("b port", 32'h5678, {16'h0, bval[0]});
		rdc("b in waveform", a_b, 32'h0);
		@(posedge ref_clk);
		wave[0] <= 1'b0;
		cnt_val[0] <= 16'h9abc;
		rdc("b in capture", a_b, 32'h5678);
		wr(a_b, 32'h0000beef);
		rdc("b write ignored", a_b, 32'h5678);
		pulse(6, 0);
		rdc("b captured", a_b, 32'h9abc);
		// Load overrun on A and B; the A read strobe clears the pending A load
		wb(1'b0, a_sr, 32'h0, q);
		pulse(1, 0);
		pulse(5, 0);
		pulse(5, 0);
		rdc("a overrun", a_sr, 32'h22, 32'hff);
		pulse(1, 0);
		pulse(5, 0);
		rdc("a no overrun", a_sr, 32'h20, 32'hff);
		pulse(6, 0);
		pulse(6, 0);
		rdc("b overrun", a_sr, 32'h42, 32'hff);
		// Event at the very edge of a clearing read survives
		fork
			wb(1'b0, a_sr, 32'h0, q);
			pulse(4, 0);
		join
		rdc("set beats clear", a_sr, 32'h10, 32'hff);
		// Mirrors: driven levels in waveform, synced pins in capture
		@(posedge ref_clk);
		wave[0] <= 1'b1;
		drv_a[0] <= 1'b1;
		clk_on[0] <= 1'b1;
		pin_b[0] <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rdc("mirror wave", a_sr, 32'h30000, 32'h70000);
		rdc("clock kept", a_sr, 32'h30000, 32'h70000);
		@(posedge ref_clk);
		wave[0] <= 1'b0;
		clk_on[0] <= 1'b0;
		repeat (4) @(posedge ref_clk);
		rdc("mirror pins", a_sr, 32'h40000, 32'h70000);
		// Mask set and clear, interrupt raised, masked, cleared
		wr(a_ier, 32'ha5);
		wr(a_ier, 32'h0);
		rdc("mask set", a_imr, 32'ha5);
		wr(a_idr, 32'h84);
		wr(a_idr, 32'h0);
		rdc("mask clear", a_imr, 32'h21);
		pulse(0, 0);
		repeat (3) @(posedge ref_clk);
		chk3("irq on", 3'b001, irq);
		wb(1'b0, a_sr, 32'h0, q);
		repeat (3) @(posedge ref_clk);
		chk3("irq cleared", 3'b000, irq);
		pulse(7, 0);
		repeat (3) @(posedge ref_clk);
		chk3("irq masked", 3'b000, irq);
		wr(8'h80 | a_ier, 32'h10);
		rdc("mask ch2", 8'h80 | a_imr, 32'h10);
		rdc("mask ch1", 8'h40 | a_imr, 32'h0);
		wr(8'h40 | a_ier, 32'hff);
		wr(8'h40 | a_idr, 32'h0f);
		rdc("mask ch1 clear", 8'h40 | a_imr, 32'hf0);
		pulse(4, 2);
		repeat (3) @(posedge ref_clk);
		chk3("irq ch2", 3'b100, irq);
		rdc("flag ch2", 8'h80 | a_sr, 32'h10, 32'hff);
		repeat (3) @(posedge ref_clk);
		chk3("irq ch2 cleared", 3'b000, irq);
		// Clock enable low freezes state: a match in that window is lost
		@(posedge ref_clk);
		en <= 1'b0;
		clk_on[1] <= 1'b1;
		pulse(4, 1);
		@(posedge ref_clk);
		en <= 1'b1;
		rdc("frozen flags", 8'h40 | a_sr, 32'h10000, 32'h100ff);
		chk3("irq frozen", 3'b000, irq);
		// Software trigger reaches all channels together
		wr(`TCS_OFF_BCR, 32'h1);
		wr(`TCS_OFF_BCR, 32'hfffffffe);
		repeat (2) @(posedge ref_clk);
		chk32("sync pulses", 32'h1, trig_cnt);
		chk32("split pulses", 32'h0, odd_cnt);
		// Clock input routing, every selector value, two pin patterns
		for (int p = 0; p < 2; p++) begin
			@(posedge ref_clk);
			xpin <= p ? 3'b101 : 3'b010;
			drv_a <= p ? 3'b010 : 3'b101;
			for (int s = 0; s < 4; s++) begin
				wr(`TCS_OFF_BMR, s | s << 2 | s << 4);
				rdc("routing", `TCS_OFF_BMR, s | s << 2 | s << 4);
				repeat (5) @(posedge ref_clk);
				chk3("clock in", {route(xpin[2], drv_a[0], drv_a[1], s),
					route(xpin[1], drv_a[0], drv_a[2], s),
					route(xpin[0], drv_a[1], drv_a[2], s)}, xin);
			end
		end
		complete_run();
	end
endmodule
`default_nettype wire
